// >>> hw/rso_pkg.sv
// Constants for the remote status output block
package rso_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int RSO_AW = 4;
  localparam int RSO_DW = 32;
  localparam int RSO_ROBOTS = 16;
  localparam int RSO_SELW = 5;
  localparam int RSO_PLANES = 15;
  localparam int RSO_ALARMS = 9;
  localparam int RSO_PROGW = 6;
  localparam int RSO_LOADW = 8;
  localparam int RSO_CNTW = 16;
  localparam int RSO_AXES = 6;
  localparam int RSO_VALW = 32;
  // ----------------------------------------------------------------
  // Register word addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] RSO_ADDR_CTRL = 4'h0;
  localparam logic [3:0] RSO_ADDR_PROG = 4'h1;
  localparam logic [3:0] RSO_ADDR_ALARM = 4'h2;
  localparam logic [3:0] RSO_ADDR_MOTOR = 4'h3;
  localparam logic [3:0] RSO_ADDR_HOME = 4'h4;
  localparam logic [3:0] RSO_ADDR_HIGH = 4'h5;
  localparam logic [3:0] RSO_ADDR_CALDONE = 4'h6;
  localparam logic [3:0] RSO_ADDR_PLANE = 4'h7;
  localparam logic [3:0] RSO_ADDR_LOAD = 4'h8;
  localparam logic [3:0] RSO_ADDR_EMERGENCY_HALT_COUNT = 4'h9;
  localparam logic [3:0] RSO_ADDR_STATUS = 4'hA;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RSO_CTRL_AUTO = 0;
  localparam int RSO_CTRL_REMOTE = 1;
  localparam int RSO_CTRL_PROGMODE = 2;
  localparam int RSO_CTRL_RIO = 3;
  localparam int RSO_ST_ALARM = 0;
  localparam int RSO_ST_ACCEPT = 1;
  localparam int RSO_ST_MOTOR = 2;
  localparam int RSO_ST_HOME = 3;
  localparam int RSO_ST_HIGH = 4;
  localparam int RSO_ST_CAL = 5;
  localparam int RSO_ST_BEAT = 6;
  // ----------------------------------------------------------------
  // Reset values and the value for invalid reals
  // ----------------------------------------------------------------
  localparam logic [3:0] RSO_CTRL_RST = 4'h0;
  localparam logic [5:0] RSO_PROG_RST = 6'h00;
  localparam logic [8:0] RSO_ALARM_RST = 9'h000;
  localparam logic [15:0] RSO_VEC_RST = 16'h0000;
  localparam logic [15:0] RSO_CALDONE_RST = 16'h0000;
  localparam logic [14:0] RSO_PLANE_RST = 15'h0000;
  localparam logic [7:0] RSO_LOAD_RST = 8'h00;
  localparam logic [15:0] RSO_CNT_RST = 16'h0000;
  localparam logic [31:0] RSO_REAL_INVALID = 32'h00000000;
endpackage

// >>> hw/rso_scope_if.sv
// Carrier between the status core and the robot scope selector
`timescale 1ns/1ns
interface rso_scope_if #(
  parameter int N = 16,
  parameter int SW = 5
);
  logic [N-1:0] motor;
  logic [N-1:0] home;
  logic [N-1:0] high;
  logic [N-1:0] cal_done;
  logic [SW-1:0] sel;
  logic motor_flag;
  logic home_flag;
  logic high_flag;
  logic cal_flag;
  modport core (
    output motor, home, high, cal_done, sel,
    input motor_flag, home_flag, high_flag, cal_flag
  );
  modport scope (
    input motor, home, high, cal_done, sel,
    output motor_flag, home_flag, high_flag, cal_flag
  );
endinterface

// >>> hw/rso_robot_scope.sv
// Per-robot status flags scoped by the robot selector
`timescale 1ns/1ns
module rso_robot_scope #(
  parameter int N = 16,
  parameter int SW = 5
) (
  rso_scope_if.scope sc
);
  // ----------------------------------------------------------------
  // Selector decode
  // ----------------------------------------------------------------
  wire all_sel = (sc.sel == '0);
  wire [N-1:0] hit;
  wire [N-1:0] not_cal = ~sc.cal_done;

  // Values past the robot count select nobody, so all flags read low
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_hit
      assign hit[i] = (sc.sel == SW'(i + 1));
    end
  endgenerate

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  assign sc.motor_flag = all_sel ? |sc.motor : |(sc.motor & hit);
  assign sc.home_flag = all_sel ? &sc.home : |(sc.home & hit);
  assign sc.high_flag = all_sel ? |sc.high : |(sc.high & hit);
  assign sc.cal_flag = all_sel ? |not_cal : |(not_cal & hit);
endmodule

// >>> hw/rso_remote_status.sv
// Remote status output generator with its register port
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module rso_remote_status
  import rso_pkg::*;
#(
  parameter int ROBOTS = RSO_ROBOTS,
  parameter int PLANES = RSO_PLANES,
  parameter int LOADW = RSO_LOADW,
  parameter int CNTW = RSO_CNTW
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [RSO_AW-1:0] reg_addr_i,
  input wire logic [RSO_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [RSO_DW-1:0] reg_rdata_o,
  input wire logic [RSO_SELW-1:0] robot_selector_i,
  input wire logic heartbeat_i,
  input wire logic emergency_halt_count_event_i,
  output logic alarm_summary_o,
  output logic [RSO_ALARMS-1:0] fault_flags_o,
  output logic [RSO_PROGW-1:0] program_number_o,
  output logic remote_accept_flag_o,
  output logic motor_power_flag_o,
  output logic home_position_flag_o,
  output logic high_power_flag_o,
  output logic calibration_needed_flag_o,
  output logic heartbeat_o,
  output logic [CNTW-1:0] emergency_halt_count_o,
  output logic [PLANES-1:0] check_plane_hit_o,
  output logic [LOADW-1:0] task_load_o,
  output logic [RSO_AXES-1:0][RSO_VALW-1:0] world_value_o,
  output logic world_valid_o,
  output logic [RSO_AXES-1:0][RSO_VALW-1:0] joint_effort_o,
  output logic joint_valid_o
);
  // ----------------------------------------------------------------
  // Software-written state and the emergency halt counter
  // ----------------------------------------------------------------
  logic [3:0] ctrl_q;
  logic [RSO_PROGW-1:0] prog_q;
  logic [RSO_ALARMS-1:0] alarm_q;
  logic [ROBOTS-1:0] motor_q;
  logic [ROBOTS-1:0] home_q;
  logic [ROBOTS-1:0] high_q;
  logic [ROBOTS-1:0] caldone_q;
  logic [PLANES-1:0] plane_q;
  logic [LOADW-1:0] load_q;
  logic [CNTW-1:0] count_q;
  logic [CNTW-1:0] count_d;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire wr_ctrl = reg_wr_i && (reg_addr_i == RSO_ADDR_CTRL);
  wire wr_prog = reg_wr_i && (reg_addr_i == RSO_ADDR_PROG);
  wire wr_alarm = reg_wr_i && (reg_addr_i == RSO_ADDR_ALARM);
  wire wr_motor = reg_wr_i && (reg_addr_i == RSO_ADDR_MOTOR);
  wire wr_home = reg_wr_i && (reg_addr_i == RSO_ADDR_HOME);
  wire wr_high = reg_wr_i && (reg_addr_i == RSO_ADDR_HIGH);
  wire wr_cal = reg_wr_i && (reg_addr_i == RSO_ADDR_CALDONE);
  wire wr_plane = reg_wr_i && (reg_addr_i == RSO_ADDR_PLANE);
  wire wr_load = reg_wr_i && (reg_addr_i == RSO_ADDR_LOAD);
  wire clr_count = reg_wr_i && (reg_addr_i == RSO_ADDR_EMERGENCY_HALT_COUNT);

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q <= RSO_CTRL_RST;
      prog_q <= RSO_PROG_RST;
      alarm_q <= RSO_ALARM_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata_i[3:0];
      end
      if (wr_prog) begin
        prog_q <= reg_wdata_i[RSO_PROGW-1:0];
      end
      if (wr_alarm) begin
        alarm_q <= reg_wdata_i[RSO_ALARMS-1:0];
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      motor_q <= ROBOTS'(RSO_VEC_RST);
      home_q <= ROBOTS'(RSO_VEC_RST);
      high_q <= ROBOTS'(RSO_VEC_RST);
      caldone_q <= ROBOTS'(RSO_CALDONE_RST);
    end else begin
      if (wr_motor) begin
        motor_q <= reg_wdata_i[ROBOTS-1:0];
      end
      if (wr_home) begin
        home_q <= reg_wdata_i[ROBOTS-1:0];
      end
      if (wr_high) begin
        high_q <= reg_wdata_i[ROBOTS-1:0];
      end
      if (wr_cal) begin
        caldone_q <= reg_wdata_i[ROBOTS-1:0];
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      plane_q <= PLANES'(RSO_PLANE_RST);
      load_q <= LOADW'(RSO_LOAD_RST);
    end else begin
      if (wr_plane) begin
        plane_q <= reg_wdata_i[PLANES-1:0];
      end
      if (wr_load) begin
        load_q <= reg_wdata_i[LOADW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Emergency halt counter
  // ----------------------------------------------------------------
  // Saturates rather than wraps, so a large count never reads small.
  // A stop in the same cycle as a clear is kept: the count restarts at 1.
  wire count_full = &count_q;
  wire [CNTW-1:0] count_inc = count_full ? count_q : count_q + 1'b1;
  always_comb begin
    count_d = count_q;
    if (emergency_halt_count_event_i) begin
      count_d = clr_count ? CNTW'(1) : count_inc;
    end else if (clr_count) begin
      count_d = CNTW'(RSO_CNT_RST);
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      count_q <= CNTW'(RSO_CNT_RST);
    end else begin
      count_q <= count_d;
    end
  end

  // ----------------------------------------------------------------
  // Robot scope
  // ----------------------------------------------------------------
  rso_scope_if #(.N(ROBOTS), .SW(RSO_SELW)) scope_bus ();
  assign scope_bus.motor = motor_q;
  assign scope_bus.home = home_q;
  assign scope_bus.high = high_q;
  assign scope_bus.cal_done = caldone_q;
  assign scope_bus.sel = robot_selector_i;

  rso_robot_scope #(.N(ROBOTS), .SW(RSO_SELW)) u_scope (
    .sc (scope_bus.scope)
  );

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  wire accept_w = (ctrl_q[RSO_CTRL_AUTO] && ctrl_q[RSO_CTRL_REMOTE]) ||
    (ctrl_q[RSO_CTRL_PROGMODE] && ctrl_q[RSO_CTRL_RIO]);
  wire summary_w = |alarm_q;

  // Everything leaves through one register rank so codes move together
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      alarm_summary_o <= 1'b0;
      fault_flags_o <= RSO_ALARM_RST;
      program_number_o <= RSO_PROG_RST;
      remote_accept_flag_o <= 1'b0;
    end else begin
      alarm_summary_o <= summary_w;
      fault_flags_o <= alarm_q;
      program_number_o <= prog_q;
      remote_accept_flag_o <= accept_w;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      motor_power_flag_o <= 1'b0;
      home_position_flag_o <= 1'b0;
      high_power_flag_o <= 1'b0;
      calibration_needed_flag_o <= 1'b0;
      heartbeat_o <= 1'b0;
    end else begin
      motor_power_flag_o <= scope_bus.motor_flag;
      home_position_flag_o <= scope_bus.home_flag;
      high_power_flag_o <= scope_bus.high_flag;
      calibration_needed_flag_o <= scope_bus.cal_flag;
      heartbeat_o <= heartbeat_i;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      emergency_halt_count_o <= CNTW'(RSO_CNT_RST);
      check_plane_hit_o <= PLANES'(RSO_PLANE_RST);
      task_load_o <= LOADW'(RSO_LOAD_RST);
    end else begin
      emergency_halt_count_o <= count_d;
      check_plane_hit_o <= plane_q;
      task_load_o <= load_q;
    end
  end

  // No position or torque source exists here; values stay at real zero
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      world_value_o <= '0;
      joint_effort_o <= '0;
      world_valid_o <= 1'b0;
      joint_valid_o <= 1'b0;
    end else begin
      world_value_o <= {RSO_AXES{RSO_REAL_INVALID}};
      joint_effort_o <= {RSO_AXES{RSO_REAL_INVALID}};
      world_valid_o <= 1'b0;
      joint_valid_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  wire [RSO_DW-1:0] status_w = RSO_DW'({heartbeat_o,
    calibration_needed_flag_o, high_power_flag_o, home_position_flag_o,
    motor_power_flag_o, remote_accept_flag_o, alarm_summary_o});
  logic [RSO_DW-1:0] rd_mux;
  always_comb begin
    case (reg_addr_i)
      RSO_ADDR_CTRL: rd_mux = RSO_DW'(ctrl_q);
      RSO_ADDR_PROG: rd_mux = RSO_DW'(prog_q);
      RSO_ADDR_ALARM: rd_mux = RSO_DW'(alarm_q);
      RSO_ADDR_MOTOR: rd_mux = RSO_DW'(motor_q);
      RSO_ADDR_HOME: rd_mux = RSO_DW'(home_q);
      RSO_ADDR_HIGH: rd_mux = RSO_DW'(high_q);
      RSO_ADDR_CALDONE: rd_mux = RSO_DW'(caldone_q);
      RSO_ADDR_PLANE: rd_mux = RSO_DW'(plane_q);
      RSO_ADDR_LOAD: rd_mux = RSO_DW'(load_q);
      RSO_ADDR_EMERGENCY_HALT_COUNT: rd_mux = RSO_DW'(count_q);
      RSO_ADDR_STATUS: rd_mux = status_w;
      default: rd_mux = '0;
    endcase
  end

  // Data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : '0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  chk_summary_alarm: assert property (
    wr_alarm |-> ##2 (alarm_summary_o == (|$past(reg_wdata_i[8:0], 2))))
    else $error("summary alarm does not match alarm bits");

  chk_local_battery: assert property (
    wr_alarm |-> ##2 (fault_flags_o[0] == $past(reg_wdata_i[0], 2)))
    else $error("local battery alarm not shown");

  chk_unit_alarms: assert property (
    wr_alarm |-> ##2 (fault_flags_o[8:1] == $past(reg_wdata_i[8:1], 2)))
    else $error("unit alarm pairs not shown");

  chk_prog_code: assert property (
    wr_prog ##1 !wr_prog |->
      ##1 (program_number_o == $past(reg_wdata_i[5:0], 2)))
    else $error("program number code wrong");

  chk_remote_accept: assert property (
    remote_accept_flag_o |->
      ($past(ctrl_q[0]) && $past(ctrl_q[1])) ||
      ($past(ctrl_q[2]) && $past(ctrl_q[3])))
    else $error("remote accept without a valid mode");

  chk_motor_all: assert property (
    (robot_selector_i == '0) && (motor_q != '0) |=> motor_power_flag_o)
    else $error("motor flag low with a motor on");

  chk_home_single: assert property (
    (robot_selector_i == 5'h03) && !home_q[2] |=> !home_position_flag_o)
    else $error("home flag high for a robot away from home");

  chk_high_scope: assert property (
    (robot_selector_i == 5'h10) |=> high_power_flag_o == $past(high_q[15]))
    else $error("high power flag ignores selected robot");

  chk_cal_any: assert property (
    (robot_selector_i == '0) && (&caldone_q) |=> !calibration_needed_flag_o)
    else $error("calibration flag high with all calibrated");

  chk_heartbeat_echo: assert property (
    $changed(heartbeat_i) |=> (heartbeat_o == $past(heartbeat_i)))
    else $error("heartbeat echo does not follow");

  chk_emergency_halt_count_count: assert property (
    emergency_halt_count_event_i && !clr_count && !count_full |=>
      emergency_halt_count_o == $past(count_q) + 1'b1)
    else $error("emergency halt count missed a stop");

  chk_plane_load: assert property (
    ##1 (check_plane_hit_o == $past(plane_q)) &&
      (task_load_o == $past(load_q)))
    else $error("plane hits or load not shown");

  chk_invalid_values: assert property (
    !world_valid_o && !joint_valid_o &&
      (world_value_o == '0) && (joint_effort_o == '0))
    else $error("unsupported values marked valid");

  chk_read_timing: assert property (
    !reg_rd_i |=> (reg_rdata_o == '0))
    else $error("read data outside the answer cycle");
endmodule

// >>> sim/rso_master_model.sv
// Model of the master control device: drives selector and heartbeat
`timescale 1ns/1ns
module rso_master_model
  import rso_pkg::*;
#(
  parameter int BEAT = 8
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [RSO_SELW-1:0] sel_cmd_i,
  input wire logic beat_echo_i,
  output logic [RSO_SELW-1:0] robot_selector_o,
  output logic heartbeat_o,
  output logic [15:0] echo_miss_o,
  output logic [15:0] beat_toggles_o
);
  // ----------------------------------------------------------------
  // Selector and heartbeat drive
  // ----------------------------------------------------------------
  // Hold times are scaled from milliseconds down to a few cycles,
  // so a block that filters short pulses would not pass here
  int cnt;
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt <= 0;
      robot_selector_o <= '0;
      heartbeat_o <= 1'b0;
      echo_miss_o <= 16'h0000;
      beat_toggles_o <= 16'h0000;
    end else begin
      robot_selector_o <= sel_cmd_i;
      cnt <= (cnt == BEAT - 1) ? 0 : cnt + 1;
      if (cnt == BEAT - 1) begin
        heartbeat_o <= ~heartbeat_o;
        beat_toggles_o <= beat_toggles_o + 16'h0001;
      end
      if (cnt == 2 && beat_echo_i !== heartbeat_o) begin
        echo_miss_o <= echo_miss_o + 16'h0001;
      end
    end
  end
endmodule

// >>> sim/remote_status_outputs_bench.sv
// Self-checking bench for the remote status output block
`timescale 1ns/1ns
module remote_status_outputs_bench
  import rso_pkg::*;
;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [RSO_AW-1:0] reg_addr_i = '0;
  logic [RSO_DW-1:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic emergency_halt_count_event_i = 1'b0;
  logic [RSO_SELW-1:0] sel_cmd = '0;
  logic [RSO_DW-1:0] reg_rdata_o;
  logic [RSO_SELW-1:0] robot_selector_i;
  logic heartbeat_i, heartbeat_o, alarm_summary_o, remote_accept_flag_o;
  logic motor_power_flag_o, home_position_flag_o, high_power_flag_o;
  logic calibration_needed_flag_o, world_valid_o, joint_valid_o;
  logic [RSO_ALARMS-1:0] fault_flags_o;
  logic [RSO_PROGW-1:0] program_number_o;
  logic [RSO_CNTW-1:0] emergency_halt_count_o;
  logic [RSO_PLANES-1:0] check_plane_hit_o;
  logic [RSO_LOADW-1:0] task_load_o;
  logic [RSO_AXES-1:0][RSO_VALW-1:0] world_value_o, joint_effort_o;
  logic [15:0] echo_miss, beat_toggles, mv, hv, pv, cv;
  logic [31:0] rv, ev;
  int n_fail = 0;
  int checks_done = 0;

  always #5 mclk_i = ~mclk_i;

  rso_remote_status rso_remote_status_i (
    .mclk_i(mclk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .robot_selector_i(robot_selector_i),
    .heartbeat_i(heartbeat_i), .emergency_halt_count_event_i(emergency_halt_count_event_i),
    .alarm_summary_o(alarm_summary_o), .fault_flags_o(fault_flags_o),
    .program_number_o(program_number_o),
    .remote_accept_flag_o(remote_accept_flag_o),
    .motor_power_flag_o(motor_power_flag_o),
    .home_position_flag_o(home_position_flag_o),
    .high_power_flag_o(high_power_flag_o),
    .calibration_needed_flag_o(calibration_needed_flag_o),
    .heartbeat_o(heartbeat_o),
    .emergency_halt_count_o(emergency_halt_count_o),
    .check_plane_hit_o(check_plane_hit_o), .task_load_o(task_load_o),
    .world_value_o(world_value_o), .world_valid_o(world_valid_o),
    .joint_effort_o(joint_effort_o), .joint_valid_o(joint_valid_o)
  );

  rso_master_model rso_master_model_i (
    .mclk_i(mclk_i), .reset_i(reset_i), .sel_cmd_i(sel_cmd),
    .beat_echo_i(heartbeat_o), .robot_selector_o(robot_selector_i),
    .heartbeat_o(heartbeat_i), .echo_miss_o(echo_miss),
    .beat_toggles_o(beat_toggles)
  );

  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe, so sample right away
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Selector above the robot count picks nobody, so every flag drops
  function automatic logic scope_exp(input logic [4:0] s,
                                     input logic [15:0] v, input bit all);
    if (s == 5'h00) return all ? &v : |v;
    if (s > 5'h10) return 1'b0;
    return v[s - 5'h01];
  endfunction

  function automatic logic accept_exp(input logic [3:0] c);
    return (c[0] & c[1]) | (c[2] & c[3]);
  endfunction

  initial begin
    repeat (50000) @(posedge mclk_i);
    n_fail++;
    $display("unexpected run length: expected end, seen timeout");
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(57602));
    repeat (5) @(posedge mclk_i);
    reset_i <= 1'b0;
    settle(2);
    chk("cal after reset", calibration_needed_flag_o, 32'h1);
    chk("summary after reset", alarm_summary_o, 32'h0);
    chk("program after reset", program_number_o, 32'h0);
    end_test("reset");
    for (int i = 0; i < RSO_ALARMS; i++) begin
      wr(RSO_ADDR_ALARM, 32'h1 << i);
      settle(2);
      chk("fault flags", fault_flags_o, 32'h1 << i);
      chk("summary", alarm_summary_o, 32'h1);
    end
    wr(RSO_ADDR_ALARM, 32'h0);
    settle(2);
    chk("summary clear", alarm_summary_o, 32'h0);
    end_test("alarms");
    for (int i = 0; i < 8; i++) begin
      rv = (i == 0) ? 32'h0 : (i == 1) ? 32'h3F : $urandom_range(62, 1);
      ev = rv;
      wr(RSO_ADDR_PROG, rv);
      settle(2);
      chk("program number", program_number_o, rv);
    end
    rd(RSO_ADDR_PROG, rv);
    chk("program readback", rv, ev);
    settle(1);
    chk("read data idle", reg_rdata_o, 32'h0);
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC, rv);
    chk("unmapped read", rv, 32'h0);
    end_test("program");
    for (int c = 0; c < 16; c++) begin
      wr(RSO_ADDR_CTRL, 32'(c));
      settle(2);
      chk("accept", remote_accept_flag_o, accept_exp(4'(c)));
    end
    end_test("accept");
    for (int r = 0; r < 4; r++) begin
      mv = 16'($urandom());
      hv = (r == 0) ? 16'hFFFF : 16'($urandom());
      pv = 16'($urandom());
      cv = (r == 1) ? 16'hFFFF : 16'($urandom());
      wr(RSO_ADDR_MOTOR, {16'h0, mv});
      wr(RSO_ADDR_HOME, {16'h0, hv});
      wr(RSO_ADDR_HIGH, {16'h0, pv});
      wr(RSO_ADDR_CALDONE, {16'h0, cv});
      for (int s = 0; s < 19; s++) begin
        @(posedge mclk_i);
        sel_cmd <= (s == 18) ? 5'h1F : 5'(s);
        settle(3);
        chk("motor", motor_power_flag_o, scope_exp(sel_cmd, mv, 0));
        chk("home", home_position_flag_o, scope_exp(sel_cmd, hv, 1));
        chk("high", high_power_flag_o, scope_exp(sel_cmd, pv, 0));
        chk("cal", calibration_needed_flag_o,
            scope_exp(sel_cmd, ~cv, 0));
      end
    end
    end_test("scope");
    // Selector picks nobody and every mode bit is set; beat bit is masked
    rd(RSO_ADDR_STATUS, rv);
    chk("status read", rv & 32'hFFFFFFBF, 32'h2);
    @(posedge mclk_i);
    emergency_halt_count_event_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    emergency_halt_count_event_i <= 1'b0;
    settle(2);
    chk("stop count", emergency_halt_count_o, 32'h3);
    rd(RSO_ADDR_EMERGENCY_HALT_COUNT, rv);
    chk("stop count read", rv, 32'h3);
    @(posedge mclk_i);
    reg_addr_i <= RSO_ADDR_EMERGENCY_HALT_COUNT;
    reg_wr_i <= 1'b1;
    emergency_halt_count_event_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    emergency_halt_count_event_i <= 1'b0;
    settle(2);
    chk("stop beats clear", emergency_halt_count_o, 32'h1);
    wr(RSO_ADDR_EMERGENCY_HALT_COUNT, 32'h0);
    settle(2);
    chk("stop cleared", emergency_halt_count_o, 32'h0);
    end_test("emergency_halt_count");
    for (int i = 0; i < 4; i++) begin
      rv = (i == 0) ? 32'hFFFFFFFF : $urandom();
      wr(RSO_ADDR_PLANE, rv);
      wr(RSO_ADDR_LOAD, rv);
      settle(2);
      chk("plane hits", check_plane_hit_o, {17'h0, rv[14:0]});
      chk("task load", task_load_o, {24'h0, rv[7:0]});
    end
    end_test("planes");
    for (int i = 0; i < RSO_AXES; i++) begin
      chk("world value", world_value_o[i], RSO_REAL_INVALID);
      chk("joint value", joint_effort_o[i], RSO_REAL_INVALID);
    end
    chk("world valid", world_valid_o, 32'h0);
    chk("joint valid", joint_valid_o, 32'h0);
    end_test("values");
    chk("echo misses", echo_miss, 32'h0);
    chk("beats sent", beat_toggles > 16'h0010, 32'h1);
    end_test("heartbeat");
    finish_test();
  end
endmodule
